//--- core/bls_exec.sv
// Purpose: executes branches, moves, loads, stores, pop/push and flag ops
// Assumes: internal memory answers mem_ack in the cycle of the request
// Notes: one instruction at a time; issue waits on issue_ready_r
`timescale 1ns/10ps
`include "bls_cfg.svh"
module bls_exec #(
	parameter int PC_W = `BLS_PC_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic issue_valid,
	input wire bls_pkg::bls_issue_t issue,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output bls_pkg::bls_mem_t mem_r,
	output bls_pkg::bls_wb_t wb_r,
	output logic issue_ready_r,
	output logic [PC_W-1:0] pc_r,
	output logic [7:0] status_register_r
);
	import bls_pkg::*;

	localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);
	localparam logic [PC_W-1:0] PC_TWO = PC_W'(2);

	logic [7:0] rf_r [32]; // register file
	logic [15:0] sp_r; // stack pointer
	bls_state_t st_r, st_nxt; // sequencer
	logic [1:0] wcnt_r, wcnt_nxt; // remaining wait cycles
	logic pend_r; // memory access follows wait
	logic [4:0] ld_rd_r; // load destination
	logic [1:0] ptr_sel_r; // pointer select of the last issue

	// index of low byte of a pointer pair
	function automatic logic [4:0] ptr_idx(input logic [1:0] sel);
		return `BLS_PTR_BASE + {2'h0, sel, 1'b0};
	endfunction

	// widen signed branch offset
	function automatic logic [PC_W-1:0] sext(input logic [6:0] k);
		return {{(PC_W-7){k[6]}}, k};
	endfunction

	// decode and address arithmetic
	wire accept = issue_valid & issue_ready_r;
	wire bls_op_t op = issue.op;
	// pair read in the open, so a write to the pair wakes these wires
	wire [4:0] ptr_lo = ptr_idx(issue.ptr_sel);
	wire [15:0] ptr = {rf_r[ptr_lo + 5'h1], rf_r[ptr_lo]};
	wire [4:0] held_lo = ptr_idx(ptr_sel_r);
	wire [15:0] ptr_held = {rf_r[held_lo + 5'h1], rf_r[held_lo]};
	wire [15:0] ptr_inc = ptr + 16'h1;
	wire [15:0] ptr_dec = ptr - 16'h1;
	wire [15:0] disp_addr = ptr + {10'h0, issue.disp};
	wire pre = issue.ptr_mode == PTR_PREDEC;
	wire ptr_upd = issue.ptr_mode != PTR_PLAIN;
	wire [15:0] ind_addr = pre ? ptr_dec : ptr;
	wire [15:0] ptr_new = pre ? ptr_dec : ptr_inc;
	wire is_ind = op == OP_LOAD_INDIRECT || op == OP_STORE_INDIRECT;
	wire is_disp = op == OP_LOAD_DISPLACED || op == OP_STORE_DISPLACED;
	wire is_load = op == OP_LOAD_DIRECT || op == OP_LOAD_INDIRECT
		|| op == OP_LOAD_DISPLACED || op == OP_POP;
	wire is_store = op == OP_STORE_INDIRECT || op == OP_STORE_DISPLACED
		|| op == OP_PUSH;
	wire [15:0] addr_nxt = op == OP_LOAD_DIRECT ? issue.addr
		: is_disp ? disp_addr
		: op == OP_POP ? sp_r + 16'h1
		: op == OP_PUSH ? sp_r : ind_addr;
	wire nvm = addr_nxt >= `BLS_NVM_BASE;
	wire [1:0] wait_n = (op == OP_LOAD_DIRECT ? `BLS_DIRECT_EXTRA : 2'h0)
		+ (nvm ? `BLS_NVM_EXTRA : 2'h0);
	wire signed_lt = status_register_r[`BLS_STATUS_REGISTER_N] ^ status_register_r[`BLS_STATUS_REGISTER_V];
	wire br_taken = (op == OP_BRANCH_SIGNED_GE && !signed_lt)
		|| (op == OP_BRANCH_SIGNED_LT && signed_lt)
		|| (op == OP_BRANCH_FLAG
		&& status_register_r[issue.flag_idx] == issue.flag_val);
	wire [PC_W-1:0] br_tgt = pc_r + sext(issue.offset) + PC_ONE;
	wire store_now = accept && is_store && !nvm;
	wire ld_done = st_r == ST_MEM && mem_ack && !mem_r.we;

	// sequencer next state
	always_comb begin
		st_nxt = st_r;
		wcnt_nxt = wcnt_r;
		case (st_r)
			ST_IDLE: begin
				if (accept && br_taken) begin
					// taken branch costs one more cycle
					st_nxt = ST_WAIT;
					wcnt_nxt = 2'h1;
				end else if (accept && wait_n != 2'h0
					&& (is_load || is_store)) begin
					st_nxt = ST_WAIT;
					wcnt_nxt = wait_n;
				end else if (accept && is_load) begin
					st_nxt = ST_MEM;
				end
			end
			ST_WAIT: begin
				if (wcnt_r == 2'h1) begin
					st_nxt = pend_r ? ST_MEM : ST_IDLE;
				end else begin
					wcnt_nxt = wcnt_r - 2'h1;
				end
			end
			ST_MEM: begin
				// slow memory may hold off the answer
				if (mem_ack) begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// sequencer and memory port
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_IDLE;
			wcnt_r <= 2'h0;
			pend_r <= 1'b0;
			ld_rd_r <= 5'h0;
			ptr_sel_r <= 2'h0;
			issue_ready_r <= 1'b0;
			mem_r <= '0;
		end else begin
			st_r <= st_nxt;
			wcnt_r <= wcnt_nxt;
			issue_ready_r <= st_nxt == ST_IDLE;
			mem_r.req <= st_nxt == ST_MEM || store_now;
			if (accept) begin
				pend_r <= is_load || is_store;
				ld_rd_r <= issue.rd;
				ptr_sel_r <= issue.ptr_sel;
				mem_r.we <= is_store;
				mem_r.addr <= addr_nxt;
				mem_r.wdata <= rf_r[issue.rr];
			end
		end
	end

	// architectural state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 32; i++) begin
				rf_r[i] <= 8'h00;
			end
			sp_r <= `BLS_SP_RESET;
			pc_r <= '0;
			status_register_r <= 8'h00;
			wb_r <= '0;
		end else begin
			wb_r.valid <= 1'b0;
			if (accept) begin
				// next sequential or branch target
				pc_r <= br_taken ? br_tgt
					: pc_r + (op == OP_LOAD_DIRECT ? PC_TWO : PC_ONE);
				if (op == OP_MOVE || op == OP_LOAD_IMM) begin
					rf_r[issue.rd] <= op == OP_MOVE ? rf_r[issue.rr]
						: issue.imm;
					wb_r <= {1'b1, issue.rd,
						op == OP_MOVE ? rf_r[issue.rr] : issue.imm};
				end
				if (is_ind && ptr_upd) begin
					// pointer moves at issue; access uses ind_addr
					rf_r[ptr_idx(issue.ptr_sel)] <= ptr_new[7:0];
					rf_r[ptr_idx(issue.ptr_sel) + 5'h1] <= ptr_new[15:8];
				end
				if (op == OP_POP) begin
					sp_r <= sp_r + 16'h1;
				end else if (op == OP_PUSH) begin
					sp_r <= sp_r - 16'h1;
				end
				if (op == OP_FLAG_WRITE) begin
					status_register_r[issue.flag_idx] <= issue.flag_val;
				end
			end else if (ld_done) begin
				rf_r[ld_rd_r] <= mem_rdata;
				wb_r <= {1'b1, ld_rd_r, mem_rdata};
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_ge_taken;
		accept && op == OP_BRANCH_SIGNED_GE && !signed_lt
		|=> pc_r == $past(br_tgt) && !issue_ready_r ##1 issue_ready_r;
	endproperty
	a_ge_taken: assert property (p_ge_taken)
		else $error("ge branch not taken in two cycles");
	property p_ge_not;
		accept && op == OP_BRANCH_SIGNED_GE && signed_lt
		|=> issue_ready_r && pc_r == $past(pc_r) + PC_ONE;
	endproperty
	a_ge_not: assert property (p_ge_not)
		else $error("ge branch fell through wrong");
	property p_lt_taken;
		accept && op == OP_BRANCH_SIGNED_LT && signed_lt
		|=> pc_r == $past(br_tgt) && $stable(status_register_r);
	endproperty
	a_lt_taken: assert property (p_lt_taken)
		else $error("lt branch target wrong");
	property p_direct;
		accept && op == OP_LOAD_DIRECT && !nvm
		|=> !mem_r.req && $stable(status_register_r) ##1 mem_r.req && !mem_r.we;
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct load timing wrong");
	property p_ld_post;
		accept && op == OP_LOAD_INDIRECT && issue.ptr_mode == PTR_POSTINC
		&& !nvm |=> mem_r.req && mem_r.addr == $past(ptr)
		&& ptr_held == $past(ptr_inc);
	endproperty
	a_ld_post: assert property (p_ld_post)
		else $error("post-increment load wrong");
	property p_ld_pre;
		accept && op == OP_LOAD_INDIRECT && issue.ptr_mode == PTR_PREDEC
		&& !nvm |=> mem_r.req && mem_r.addr == $past(ptr_dec)
		&& ptr_held == $past(ptr_dec);
	endproperty
	a_ld_pre: assert property (p_ld_pre)
		else $error("pre-decrement load wrong");
	property p_ld_disp;
		accept && op == OP_LOAD_DISPLACED && !nvm
		|=> mem_r.addr == $past(disp_addr)
		&& ptr_held == $past(ptr);
	endproperty
	a_ld_disp: assert property (p_ld_disp)
		else $error("displaced load wrong");
	property p_st_disp;
		accept && op == OP_STORE_DISPLACED && !nvm
		|=> mem_r.req && mem_r.we && issue_ready_r
		&& mem_r.addr == $past(disp_addr);
	endproperty
	a_st_disp: assert property (p_st_disp)
		else $error("displaced store wrong");
	property p_st_post;
		accept && op == OP_STORE_INDIRECT && issue.ptr_mode == PTR_POSTINC
		&& !nvm |=> mem_r.we && issue_ready_r && mem_r.addr == $past(ptr)
		&& ptr_held == $past(ptr_inc);
	endproperty
	a_st_post: assert property (p_st_post)
		else $error("post-increment store wrong");
	property p_st_pre;
		accept && op == OP_STORE_INDIRECT && issue.ptr_mode == PTR_PREDEC
		&& !nvm |=> mem_r.we && mem_r.addr == $past(ptr_dec)
		&& $stable(status_register_r);
	endproperty
	a_st_pre: assert property (p_st_pre)
		else $error("pre-decrement store wrong");
	property p_pop;
		accept && op == OP_POP && !nvm |=> mem_r.req && !issue_ready_r
		&& mem_r.addr == $past(sp_r) + 16'h1 && sp_r == mem_r.addr;
	endproperty
	a_pop: assert property (p_pop)
		else $error("pop wrong");
	property p_flag;
		accept && op == OP_FLAG_WRITE |=> issue_ready_r
		&& ((status_register_r ^ $past(status_register_r))
		& ~(8'h01 << $past(issue.flag_idx))) == 8'h00
		&& status_register_r[$past(issue.flag_idx)] == $past(issue.flag_val);
	endproperty
	a_flag: assert property (p_flag)
		else $error("flag write wrong");
	property p_nvm;
		accept && (is_load || is_store) && nvm && op != OP_LOAD_DIRECT
		|=> !mem_r.req ##1 mem_r.req;
	endproperty
	a_nvm: assert property (p_nvm)
		else $error("slow memory extra cycle missing");
	property p_back;
		accept && br_taken && issue.offset[6] |=> pc_r <= $past(pc_r);
	endproperty
	a_back: assert property (p_back)
		else $error("negative offset went forward");

	c_taken: cover property (accept && br_taken);
	c_nvm_load: cover property (accept && is_load && nvm);
	c_pop: cover property (accept && op == OP_POP ##1 ld_done);
endmodule

//--- core/bls_cfg.svh
// Purpose: constants of the branch, load/store and flag execution unit
// Assumes: 8-bit registers, 16-bit data space, pointers in r26..r31
// Notes: offsets into the status byte and memory map are fixed here
// Notes on behaviour
// - signed ge branch jumps when n^v clear, 1/2
// - signed lt branch jumps when n^v set
// - direct load takes three cycles, no flags
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - displaced load reads pointer plus q, unchanged
// - displaced store writes pointer plus q, 1 cycle
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
// - pop reads stack into register, two cycles
// - flag set/clear touches one status bit only
// - slow-memory accesses take at least one extra
`ifndef BLS_CFG_SVH
`define BLS_CFG_SVH
`define BLS_PC_W 16
`define BLS_SP_RESET 16'h01ff
`define BLS_NVM_BASE 16'h4000
`define BLS_NVM_EXTRA 2'h1
`define BLS_DIRECT_EXTRA 2'h1
`define BLS_PTR_BASE 5'h1a
`define BLS_STATUS_REGISTER_N 3'h2
`define BLS_STATUS_REGISTER_V 3'h3
`endif

//--- core/bls_pkg.sv
// Purpose: types of the branch, load/store and flag execution unit
// Assumes: instructions arrive already decoded
// Notes: pointer select 0, 1, 2 picks the first, second, third pair
package bls_pkg;
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_BRANCH_SIGNED_GE = 4'h1,
		OP_BRANCH_SIGNED_LT = 4'h2,
		OP_BRANCH_FLAG = 4'h3,
		OP_MOVE = 4'h4,
		OP_LOAD_IMM = 4'h5,
		OP_LOAD_DIRECT = 4'h6,
		OP_LOAD_INDIRECT = 4'h7,
		OP_LOAD_DISPLACED = 4'h8,
		OP_STORE_INDIRECT = 4'h9,
		OP_STORE_DISPLACED = 4'ha,
		OP_POP = 4'hb,
		OP_PUSH = 4'hc,
		OP_FLAG_WRITE = 4'hd
	} bls_op_t;
	typedef enum logic [1:0] {
		PTR_PLAIN = 2'h0,
		PTR_POSTINC = 2'h1,
		PTR_PREDEC = 2'h2
	} bls_ptr_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_MEM = 2'b10
	} bls_state_t;
	typedef struct packed {
		bls_op_t op;
		bls_ptr_mode_t ptr_mode;
		logic [1:0] ptr_sel;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [5:0] disp;
		logic [6:0] offset;
		logic [15:0] addr;
		logic [7:0] imm;
		logic [2:0] flag_idx;
		logic flag_val;
	} bls_issue_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bls_mem_t;
	typedef struct packed {
		logic valid;
		logic [4:0] idx;
		logic [7:0] data;
	} bls_wb_t;
endpackage

//--- testbench/bls_mem_model.sv
// Purpose: data memory facing the execution unit
// Assumes: internal region answers in the cycle of the request
// Notes: slow region stalls one cycle more; idle read data keeps moving
`timescale 1ns/10ps
module bls_mem_model (
	input wire logic clk,
	input wire bls_pkg::bls_mem_t mem,
	output logic ack,
	output logic [7:0] rdata
);
	import bls_pkg::*;
	logic [7:0] ram [0:255]; // byte store on low address bits
	logic seen_r; // slow access already waited once
	logic [7:0] idle_r; // filler while nothing is answered
	wire slow = mem.addr >= 16'h4000;
	assign ack = mem.req & (!slow | seen_r);
	assign rdata = ack ? ram[mem.addr[7:0]] : idle_r;
	// known contents: byte at a holds a plus 0x30
	initial begin
		for (int i = 0; i < 256; i++)
			ram[i] = 8'(i) + 8'h30;
		idle_r = 8'h00;
		seen_r = 1'b0;
	end
	// writes land and slow waits are counted on the edge
	always @(posedge clk) begin
		idle_r <= idle_r + 8'h3b;
		seen_r <= mem.req & slow & !ack;
		if (mem.req && mem.we && ack)
			ram[mem.addr[7:0]] <= mem.wdata;
	end
endmodule

//--- testbench/tb_bls_exec.sv
// Purpose: self-checking bench of the execution unit
// Assumes: memory model answers loads, stores and stack traffic
// Notes: pc is tracked here and compared after every row
`timescale 1ns/10ps
module tb_bls_exec;
	import bls_pkg::*;
	typedef struct {
		bls_issue_t i; // instruction
		int c; // expected cycle count
		bit t; // branch taken
		logic [15:0] a; // expected memory address
		logic [15:0] d; // expected data moved
		logic [15:0] f; // expected status byte
	} bls_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic issue_valid = 1'b0;
	bls_issue_t issue = '0;
	logic mem_ack;
	logic [7:0] mem_rdata;
	bls_mem_t mem_r;
	bls_wb_t wb_r;
	logic issue_ready_r;
	logic [15:0] pc_r;
	logic [7:0] status_register_r;
	int mismatches = 0;
	int cmp_count = 0;
	logic [15:0] pc_e = 16'h0000; // expected program counter
	bls_row_t rows[$];
	bls_row_t slow_row; // slow load cut short by reset
	bls_exec dut (.clk(clk), .rstn(rstn), .issue_valid(issue_valid),
		.issue(issue), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.mem_r(mem_r), .wb_r(wb_r), .issue_ready_r(issue_ready_r),
		.pc_r(pc_r), .status_register_r(status_register_r));
	bls_mem_model mem (.clk(clk), .mem(mem_r), .ack(mem_ack),
		.rdata(mem_rdata));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// v packs imm, disp, offset, addr, rr of a move, flag at [11:8]
	function automatic bls_row_t rw(bls_op_t o, int m, s, r, v, c, t,
		a, d, f);
		bls_row_t x;
		x.i = '0;
		x.i.op = o;
		x.i.ptr_mode = bls_ptr_mode_t'(m);
		x.i.ptr_sel = 2'(s);
		x.i.rd = 5'(r);
		x.i.rr = (o == OP_MOVE) ? 5'(v) : 5'(r);
		x.i.disp = 6'(v);
		x.i.offset = 7'(v);
		x.i.addr = 16'(v);
		x.i.imm = 8'(v);
		x.i.flag_idx = 3'(v >> 9);
		x.i.flag_val = v[8];
		x.c = c;
		x.t = t[0];
		x.a = 16'(a);
		x.d = 16'(d);
		x.f = 16'(f);
		return x;
	endfunction
	// offer one instruction, then watch it until ready returns
	task automatic run(bls_row_t r);
		int n, g;
		logic [15:0] sa, sd, wi, wx;
		n = 1;
		g = 0;
		sa = 16'hffff;
		sd = 16'h0000;
		wi = 16'hffff;
		wx = 16'hffff;
		if (r.i.op inside {OP_MOVE, OP_LOAD_IMM, OP_LOAD_DIRECT,
			OP_LOAD_INDIRECT, OP_LOAD_DISPLACED, OP_POP})
			wx = {11'h000, r.i.rd};
		@(posedge clk);
		issue <= r.i;
		issue_valid <= 1'b1;
		// ready is looked at between edges, where it has settled
		@(negedge clk);
		while (issue_ready_r !== 1'b1 && g < 20) begin
			g++;
			@(negedge clk);
		end
		@(posedge clk);
		issue_valid <= 1'b0;
		g = 0;
		@(negedge clk);
		while (g < 40) begin
			if (mem_r.req === 1'b1)
				sa = mem_r.addr;
			if (mem_r.req === 1'b1 && mem_r.we === 1'b1)
				sd = {8'h00, mem_r.wdata};
			if (wb_r.valid === 1'b1)
				sd = {8'h00, wb_r.data};
			if (wb_r.valid === 1'b1)
				wi = {11'h000, wb_r.idx};
			if (issue_ready_r === 1'b1)
				break;
			n++;
			g++;
			@(negedge clk);
		end
		if (r.t)
			pc_e = pc_e + 16'($signed(r.i.offset)) + 16'h0001;
		else
			pc_e = pc_e + ((r.i.op == OP_LOAD_DIRECT) ? 16'h2 : 16'h1);
		chk("settled", {15'h0, issue_ready_r}, 16'h0001);
		chk("cycles", 16'(n), 16'(r.c));
		chk("dest", wi, wx);
		chk("address", sa, r.a);
		chk("data", sd, r.d);
		chk("pc", pc_r, pc_e);
		chk("status", {8'h00, status_register_r}, r.f);
	endtask
	initial begin
		#20000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		rows = '{rw(OP_LOAD_IMM, 0, 0, 26, 'h10, 1, 0, 'hffff, 'h10, 0),
			rw(OP_LOAD_INDIRECT, 1, 0, 1, 0, 2, 0, 'h10, 'h40, 0),
			rw(OP_LOAD_INDIRECT, 0, 0, 2, 0, 2, 0, 'h11, 'h41, 0),
			rw(OP_LOAD_INDIRECT, 2, 0, 3, 0, 2, 0, 'h10, 'h40, 0),
			rw(OP_STORE_INDIRECT, 1, 0, 1, 0, 1, 0, 'h10, 'h40, 0),
			rw(OP_STORE_INDIRECT, 2, 0, 2, 0, 1, 0, 'h10, 'h41, 0),
			rw(OP_LOAD_INDIRECT, 0, 0, 9, 0, 2, 0, 'h10, 'h41, 0),
			rw(OP_LOAD_IMM, 0, 0, 28, 'h20, 1, 0, 'hffff, 'h20, 0),
			rw(OP_LOAD_DISPLACED, 0, 1, 4, 'h3f, 2, 0, 'h5f, 'h8f, 0),
			rw(OP_STORE_DISPLACED, 0, 1, 4, 5, 1, 0, 'h25, 'h8f, 0),
			rw(OP_LOAD_INDIRECT, 0, 1, 5, 0, 2, 0, 'h20, 'h50, 0),
			rw(OP_LOAD_DIRECT, 0, 0, 6, 'h33, 3, 0, 'h33, 'h63, 0),
			rw(OP_LOAD_DIRECT, 0, 0, 7, 'h4001, 5, 0, 'h4001, 'h31, 0),
			rw(OP_PUSH, 0, 0, 4, 0, 1, 0, 'h1ff, 'h8f, 0),
			rw(OP_POP, 0, 0, 8, 0, 2, 0, 'h1ff, 'h8f, 0),
			rw(OP_MOVE, 0, 0, 10, 8, 1, 0, 'hffff, 'h8f, 0),
			rw(OP_LOAD_IMM, 0, 0, 31, 'h40, 1, 0, 'hffff, 'h40, 0),
			rw(OP_LOAD_IMM, 0, 0, 30, 5, 1, 0, 'hffff, 'h05, 0),
			rw(OP_STORE_INDIRECT, 0, 2, 4, 0, 4, 0, 'h4005, 'h8f, 0),
			rw(OP_LOAD_INDIRECT, 0, 2, 12, 0, 4, 0, 'h4005, 'h8f, 0),
			rw(OP_FLAG_WRITE, 0, 0, 0, 'hb00, 1, 0, 'hffff, 0, 'h20),
			rw(OP_FLAG_WRITE, 0, 0, 0, 'h700, 1, 0, 'hffff, 0, 'h28),
			rw(OP_BRANCH_SIGNED_GE, 0, 0, 0, 5, 1, 0, 'hffff, 0, 'h28),
			rw(OP_BRANCH_SIGNED_LT, 0, 0, 0, 'h7e, 2, 1, 'hffff, 0, 'h28),
			rw(OP_FLAG_WRITE, 0, 0, 0, 'h500, 1, 0, 'hffff, 0, 'h2c),
			rw(OP_BRANCH_SIGNED_GE, 0, 0, 0, 3, 2, 1, 'hffff, 0, 'h2c),
			rw(OP_BRANCH_SIGNED_LT, 0, 0, 0, 3, 1, 0, 'hffff, 0, 'h2c),
			rw(OP_BRANCH_FLAG, 0, 0, 0, 'hb7f, 2, 1, 'hffff, 0, 'h2c),
			rw(OP_FLAG_WRITE, 0, 0, 0, 'h400, 1, 0, 'hffff, 0, 'h28)};
		// reset held three cycles, ready one edge after release
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("ready", {15'h0, issue_ready_r}, 16'h0000);
		@(negedge clk);
		chk("ready", {15'h0, issue_ready_r}, 16'h0001);
		foreach (rows[k]) begin
			run(rows[k]);
			$display("row %0d done", k);
		end
		// reset lands while a slow load waits for its answer
		slow_row = rw(OP_LOAD_INDIRECT, 0, 2, 13, 0, 4, 0, 'h4005, 0, 0);
		@(posedge clk);
		issue <= slow_row.i;
		issue_valid <= 1'b1;
		@(posedge clk);
		issue_valid <= 1'b0;
		@(negedge clk);
		chk("request", {15'h0, mem_r.req}, 16'h0000);
		@(negedge clk);
		chk("request", {15'h0, mem_r.req}, 16'h0001);
		@(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		chk("pc", pc_r, 16'h0000);
		chk("status", {8'h00, status_register_r}, 16'h0000);
		chk("request", {15'h0, mem_r.req}, 16'h0000);
		chk("ready", {15'h0, issue_ready_r}, 16'h0000);
		chk("writeback", {15'h0, wb_r.valid}, 16'h0000);
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("ready", {15'h0, issue_ready_r}, 16'h0000);
		@(negedge clk);
		chk("ready", {15'h0, issue_ready_r}, 16'h0001);
		pc_e = 16'h0000;
		run(rw(OP_LOAD_INDIRECT, 0, 0, 11, 0, 2, 0, 'h0, 'h30, 0));
		$display("reset test done");
		report_and_stop();
	end
endmodule
